// file: hw/uvf_fault_ctrl.sv
// output under-voltage fault response sequencer with its config register
// assumes a command decoder on clk_sys and an asynchronous fault comparator
`include "uvf_params.svh"

module uvf_fault_ctrl (
  // clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rstn,
  // command port
  input  wire uvf_pkg::uvf_cmd_type  cmd,
  output logic [`UVF_CMD_W-1:0]      rdData,
  output logic                       rdValid,
  // fault sources and time base
  input  wire logic                  uvFault,
  input  wire logic                  unitTick,
  input  wire logic                  faultClear,
  input  wire logic                  shutdownReq,
  // response
  output logic                       outEnable,
  output logic                       latchedOff,
  output logic [2:0]                 attempts,
  output uvf_pkg::uvf_state_type     seqState
);
  import uvf_pkg::*;

  // *********************************************************
  // decode helpers
  // *********************************************************
  function automatic logic regHit(input logic [`UVF_CMD_W-1:0] code);
    regHit = (code == `UVF_CMD_RESPONSE);
  endfunction

  // another attempt is allowed below the limit or when unlimited
  function automatic logic moreRetries(input logic [2:0] limit,
                                       input logic [2:0] done);
    moreRetries = (limit == `UVF_RETRY_FOREVER) || (done < limit);
  endfunction

  // saturates so the continuous case never wraps to zero
  function automatic logic [2:0] bump(input logic [2:0] done);
    bump = (done == 3'h7) ? done : done + 3'h1;
  endfunction

  // *********************************************************
  // state and timer
  // *********************************************************
  uvf_ctrl_type s_r;
  uvf_ctrl_type s_nxt;
  logic         tmrStart;
  logic         tmrExpire;
  logic         fault;
  logic [1:0]   action;
  logic [2:0]   retryLimit;

  assign fault      = s_r.faultS2;
  assign action     = s_r.cfg[`UVF_RESP_HI:`UVF_RESP_LO];
  assign retryLimit = s_r.cfg[`UVF_RETRY_HI:`UVF_RETRY_LO];

  uvf_unit_timer #(
    .CODE_W  (`UVF_CODE_W),
    .UNITS_W (`UVF_UNITS_W)
  ) u_timer (
    .clk_sys   (clk_sys),
    .rstn      (rstn),
    .start     (tmrStart),
    .unitTick  (unitTick),
    .delayCode (s_r.cfg[`UVF_DELAY_HI:`UVF_DELAY_LO]),
    .expire    (tmrExpire)
  );

  // *********************************************************
  // next state
  // *********************************************************
  always_comb begin
    s_nxt    = s_r;
    tmrStart = 1'b0;

    // fault comes from an analog comparator, so two stages first
    s_nxt.faultS1 = uvFault;
    s_nxt.faultS2 = s_r.faultS1;

    // register access
    s_nxt.rdValid = cmd.read;
    s_nxt.rdData  = (cmd.read && regHit(cmd.code)) ? s_r.cfg : 8'h00;
    if (cmd.write && regHit(cmd.code)) begin
      s_nxt.cfg = cmd.data;
    end

    case (s_r.state)
      UVF_RUN: begin
        s_nxt.outEnable = 1'b1;
        if (fault) begin
          case (action)
            `UVF_ACT_IGNORE: begin
              s_nxt.outEnable = 1'b1;
            end
            `UVF_ACT_DELAYED: begin
              s_nxt.state = UVF_DELAY;
              tmrStart    = 1'b1;
            end
            `UVF_ACT_DISABLE: begin
              s_nxt.outEnable = 1'b0;
              s_nxt.attempts  = 3'h0;
              if (retryLimit == `UVF_RETRY_NONE) begin
                s_nxt.state   = UVF_LATCH;
                s_nxt.latched = 1'b1;
              end else begin
                s_nxt.state = UVF_WAIT;
                tmrStart    = 1'b1;
              end
            end
            default: begin
              s_nxt.outEnable = 1'b0;
              s_nxt.state     = UVF_HOLD;
            end
          endcase
        end
      end
      UVF_DELAY: begin
        if (!fault) begin
          s_nxt.state = UVF_RUN;
        end else if (tmrExpire) begin
          s_nxt.outEnable = 1'b0;
          s_nxt.attempts  = 3'h0;
          if (retryLimit == `UVF_RETRY_NONE) begin
            s_nxt.state   = UVF_LATCH;
            s_nxt.latched = 1'b1;
          end else begin
            s_nxt.state = UVF_WAIT;
            tmrStart    = 1'b1;
          end
        end
      end
      UVF_WAIT: begin
        s_nxt.outEnable = 1'b0;
        if (tmrExpire) begin
          // first attempt passes rearm too, so every start looks alike
          s_nxt.state    = UVF_REARM;
          s_nxt.attempts = bump(s_r.attempts);
          tmrStart       = 1'b1;
        end
      end
      UVF_TRY: begin
        if (tmrExpire) begin
          if (!fault) begin
            s_nxt.state    = UVF_RUN;
            s_nxt.attempts = 3'h0;
          end else if (moreRetries(retryLimit, s_r.attempts)) begin
            // one off cycle marks the new attempt; timer already runs
            s_nxt.state     = UVF_REARM;
            s_nxt.outEnable = 1'b0;
            s_nxt.attempts  = bump(s_r.attempts);
            tmrStart        = 1'b1;
          end else begin
            s_nxt.state     = UVF_LATCH;
            s_nxt.outEnable = 1'b0;
            s_nxt.latched   = 1'b1;
          end
        end
      end
      UVF_REARM: begin
        s_nxt.state     = UVF_TRY;
        s_nxt.outEnable = 1'b1;
      end
      UVF_LATCH: begin
        s_nxt.outEnable = 1'b0;
      end
      UVF_HOLD: begin
        s_nxt.outEnable = 1'b0;
        if (!fault) begin
          s_nxt.state     = UVF_RUN;
          s_nxt.outEnable = 1'b1;
        end
      end
      default: begin
        s_nxt.state     = UVF_LATCH;
        s_nxt.outEnable = 1'b0;
        s_nxt.latched   = 1'b1;
      end
    endcase

    // shutdown from elsewhere ends any delay or retry sequence
    if (shutdownReq && (s_r.state != UVF_RUN) && (s_r.state != UVF_HOLD)
        && (s_r.state != UVF_LATCH)) begin
      s_nxt.state     = UVF_LATCH;
      s_nxt.outEnable = 1'b0;
      s_nxt.latched   = 1'b1;
      tmrStart        = 1'b0;
    end

    // clear releases the latch; it does not abort a running retry
    if (faultClear) begin
      s_nxt.attempts = 3'h0;
      if (s_r.state == UVF_LATCH) begin
        s_nxt.state     = UVF_RUN;
        s_nxt.outEnable = 1'b1;
        s_nxt.latched   = 1'b0;
      end
    end
  end

  // *********************************************************
  // registers
  // *********************************************************
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s_r           <= '0;
      s_r.state     <= UVF_RUN;
      s_r.cfg       <= `UVF_RESP_RESET;
      s_r.outEnable <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // *********************************************************
  // outputs
  // *********************************************************
  assign rdData     = s_r.rdData;
  assign rdValid    = s_r.rdValid;
  assign outEnable  = s_r.outEnable;
  assign latchedOff = s_r.latched;
  assign attempts   = s_r.attempts;
  assign seqState   = s_r.state;

endmodule

// file: hw/uvf_params.svh
// constants for the under-voltage fault response block
// assumes one 250 MHz clock and a unit tick made elsewhere
`ifndef UVF_PARAMS_SVH
`define UVF_PARAMS_SVH

// ***********************************************************
// command code and register layout
// ***********************************************************
`define UVF_CMD_W         8
`define UVF_CMD_RESPONSE  8'h45
`define UVF_RESP_RESET    8'h00
`define UVF_RESP_HI       7
`define UVF_RESP_LO       6
`define UVF_RETRY_HI      5
`define UVF_RETRY_LO      3
`define UVF_DELAY_HI      2
`define UVF_DELAY_LO      0

// ***********************************************************
// field encodings
// ***********************************************************
`define UVF_ACT_IGNORE    2'h0
`define UVF_ACT_DELAYED   2'h1
`define UVF_ACT_DISABLE   2'h2
`define UVF_ACT_HOLD      2'h3
`define UVF_RETRY_NONE    3'h0
`define UVF_RETRY_FOREVER 3'h7

// ***********************************************************
// timer sizing
// ***********************************************************
`define UVF_CODE_W        3
`define UVF_UNITS_W       8

`endif

// file: hw/uvf_pkg.sv
// types shared by the under-voltage fault response block
// assumes uvf_params.svh on the include path
`include "uvf_params.svh"

package uvf_pkg;

  // *********************************************************
  // command port carrier
  // *********************************************************
  typedef struct packed {
    logic                   write;
    logic                   read;
    logic [`UVF_CMD_W-1:0]  code;
    logic [`UVF_CMD_W-1:0]  data;
  } uvf_cmd_type;

  // *********************************************************
  // sequencer states
  // *********************************************************
  typedef enum logic [2:0] {
    UVF_RUN   = 3'b000,
    UVF_DELAY = 3'b001,
    UVF_WAIT  = 3'b010,
    UVF_TRY   = 3'b011,
    UVF_REARM = 3'b100,
    UVF_LATCH = 3'b101,
    UVF_HOLD  = 3'b110
  } uvf_state_type;

  typedef struct packed {
    logic                    busy;
    logic [`UVF_UNITS_W-1:0] remain;
    logic                    expire;
  } uvf_timer_type;

  typedef struct packed {
    uvf_state_type          state;
    logic [`UVF_CMD_W-1:0]  cfg;
    logic [2:0]             attempts;
    logic                   outEnable;
    logic                   latched;
    logic [`UVF_CMD_W-1:0]  rdData;
    logic                   rdValid;
    logic                   faultS1;
    logic                   faultS2;
  } uvf_ctrl_type;

endpackage

// file: hw/uvf_unit_timer.sv
// delay timer counting 2**code ticks of the fault time unit
// assumes unitTick is a one-cycle pulse on clk_sys
`include "uvf_params.svh"

module uvf_unit_timer #(
  parameter int CODE_W  = `UVF_CODE_W,
  parameter int UNITS_W = `UVF_UNITS_W
) (
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rstn,
  // control
  input  wire logic              start,
  input  wire logic              unitTick,
  input  wire logic [CODE_W-1:0] delayCode,
  // result
  output logic                   expire
);
  import uvf_pkg::*;

  uvf_timer_type s_r;
  uvf_timer_type s_nxt;

  always_comb begin
    s_nxt        = s_r;
    s_nxt.expire = 1'b0;
    // restart wins so a fresh interval always begins on start
    if (start) begin
      s_nxt.busy   = 1'b1;
      s_nxt.remain = UNITS_W'(1) << delayCode;
    end else if (s_r.busy && unitTick) begin
      if (s_r.remain == UNITS_W'(1)) begin
        s_nxt.busy   = 1'b0;
        s_nxt.expire = 1'b1;
      end else begin
        s_nxt.remain = s_r.remain - UNITS_W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign expire = s_r.expire;

endmodule

// file: verification/uv_fault_response_ctrl_test.sv
// self-checking bench for the fault response sequencer
// assumes the host model owns the command port
module uv_fault_response_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  import uvf_pkg::*;
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
  localparam int TP = 4;
  logic clk_sys, rstn, uvFault, unitTick, faultClear, shutdownReq;
  logic rdValid, outEnable, latchedOff, prev, early;
  logic [7:0] rdData, rd;
  logic [2:0] attempts;
  uvf_cmd_type cmd;
  uvf_state_type seqState;
  int fail_count, n_checks, rises, last, cyc;
  uvf_fault_ctrl DUT (.clk_sys, .rstn, .cmd, .rdData, .rdValid, .uvFault,
    .unitTick, .faultClear, .shutdownReq, .outEnable, .latchedOff,
    .attempts, .seqState);
  uvf_host_model HOST (.clk_sys, .rdData, .rdValid, .cmd);
  initial begin
    clk_sys = 0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(negedge clk_sys) begin
    cyc++;
    unitTick <= (cyc % TP == 0);
  end
  // ********
  // tasks
  // ********
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic cyc_n(int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic cfg(logic [7:0] v);
    HOST.wr(8'h45, v);
    HOST.rd(8'h45, rd);
    `CHK(rd, v)
  endtask
  task automatic run_case(logic [1:0] a, logic [2:0] r, logic [2:0] c);
    cfg({a, r, c});
    rises = 0;
    last = 0;
    prev = 1;
    uvFault = 1;
    for (int i = 0; i < 4000 && !latchedOff && rises < 9; i++) begin
      @(negedge clk_sys);
      // third negedge: synced fault has acted, loop not yet left
      if (i == 2) early = outEnable;
      if (outEnable === 1'b1 && prev === 1'b0) begin
        if (rises > 0) `CHK(i - last, TP << c)
        rises++;
        last = i;
      end
      prev = outEnable;
    end
    `CHK(early, a == 2'h1)
    if (r == 3'h7) begin
      `CHK(rises, 9)
      shutdownReq = 1;
      cyc_n(1);
      shutdownReq = 0;
      cyc_n(2);
    end else `CHK(rises, int'(r))
    `CHK(latchedOff, 1'b1)
    `CHK(attempts, r)
    uvFault = 0;
    cyc_n(4);
    `CHK(outEnable, 1'b0)
    faultClear = 1;
    cyc_n(1);
    faultClear = 0;
    cyc_n(2);
    `CHK({outEnable, attempts}, 4'h8)
    $display("case %h %h %h done", a, r, c);
  endtask
  // ********
  // sequence
  // ********
  initial begin
    {rstn, uvFault, faultClear, shutdownReq} = 4'h0;
    void'($urandom(32'h23BC2C67));
    cyc_n(6);
    rstn = 1;
    HOST.rd(8'h45, rd);
    `CHK(rd, 8'h00)
    HOST.wr(8'h46, 8'hFF);
    HOST.rd(8'h46, rd);
    `CHK(rd, 8'h00)
    cfg({2'h0, 6'($urandom)});
    uvFault = 1;
    cyc_n(300);
    `CHK(outEnable, 1'b1)
    cfg({2'h3, 6'($urandom)});
    cyc_n(4);
    `CHK(outEnable, 1'b0)
    uvFault = 0;
    cyc_n(5);
    `CHK(outEnable, 1'b1)
    $display("ignore and hold done");
    for (int r = 0; r < 8; r++) run_case(2'h2, 3'(r), 3'($urandom_range(2)));
    run_case(2'h1, 3'h0, 3'h2);
    run_case(2'h1, 3'($urandom_range(6)), 3'h2);
    // fault leaves during the first attempt: restart succeeds
    cfg({2'h2, 3'h3, 3'h1});
    uvFault = 1;
    for (int i = 0; i < 200 && attempts !== 3'h1; i++) @(negedge clk_sys);
    `CHK(attempts, 3'h1)
    uvFault = 0;
    cyc_n(20);
    `CHK({latchedOff, outEnable, attempts}, 5'h08)
    $display("recovery done");
    give_verdict();
  end
  initial begin
    #400000;
    fail_count++;
    give_verdict();
  end
endmodule

// file: verification/uvf_fault_ctrl_assertions.sv
// port assertions for the fault response sequencer
// assumes one clock domain, bound onto uvf_fault_ctrl
module uvf_fault_ctrl_checker (
  // clock and reset
  input wire logic                   clk_sys,
  input wire logic                   rstn,
  // command port
  input wire uvf_pkg::uvf_cmd_type   cmd,
  input wire logic [7:0]             rdData,
  input wire logic                   rdValid,
  // fault inputs and response
  input wire logic                   faultClear,
  input wire logic                   shutdownReq,
  input wire logic                   outEnable,
  input wire logic                   latchedOff,
  input wire logic [2:0]             attempts,
  input wire uvf_pkg::uvf_state_type seqState
);
  timeunit 1ns;
  timeprecision 1ps;
  import uvf_pkg::*;
  // ********
  // checks
  // ********
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // shutdown may take rearm straight to latch
  sequence s_rearm; seqState == UVF_REARM && !shutdownReq; endsequence
  sequence s_retry; seqState == UVF_TRY && outEnable; endsequence
  // stable guard: outputs may settle on the edge after a state change
  property p_run_on;
    $stable(seqState) && seqState == UVF_RUN |-> outEnable;
  endproperty
  property p_delay_on; seqState == UVF_DELAY |-> outEnable; endproperty
  property p_hold_off;
    $stable(seqState) && seqState == UVF_HOLD |-> !outEnable;
  endproperty
  property p_latch_off;
    $stable(seqState) && seqState == UVF_LATCH |-> latchedOff && !outEnable;
  endproperty
  property p_rearm; s_rearm |=> s_retry; endproperty
  property p_shut;
    shutdownReq && seqState inside {UVF_DELAY, UVF_WAIT, UVF_TRY, UVF_REARM}
      |=> seqState == UVF_LATCH;
  endproperty
  property p_clear;
    faultClear && seqState == UVF_LATCH
      |=> seqState == UVF_RUN && attempts == 3'h0;
  endproperty
  property p_rd;
    cmd.read && cmd.code != 8'h45 |=> rdValid && rdData == 8'h00;
  endproperty
  a_run_on: assert property (p_run_on)
    else $error("output off in run");
  a_delay_on: assert property (p_delay_on)
    else $error("output off in delay");
  a_hold_off: assert property (p_hold_off)
    else $error("output on in hold");
  a_latch_off: assert property (p_latch_off)
    else $error("latch state not off");
  a_rearm: assert property (p_rearm)
    else $error("rearm not followed by try");
  a_shut: assert property (p_shut)
    else $error("shutdown did not latch");
  a_clear: assert property (p_clear)
    else $error("clear did not restart");
  a_rd: assert property (p_rd)
    else $error("bad read of other code");
endmodule

bind uvf_fault_ctrl uvf_fault_ctrl_checker u_chk (
  .clk_sys(clk_sys), .rstn(rstn), .cmd(cmd), .rdData(rdData),
  .rdValid(rdValid), .faultClear(faultClear), .shutdownReq(shutdownReq),
  .outEnable(outEnable), .latchedOff(latchedOff), .attempts(attempts),
  .seqState(seqState));

// file: verification/uvf_host_model.sv
// host model issuing register writes and reads
// assumes the bench calls wr and rd only after reset release
module uvf_host_model (
  // clock
  input wire logic          clk_sys,
  // read return
  input wire logic [7:0]    rdData,
  input wire logic          rdValid,
  // command
  output uvf_pkg::uvf_cmd_type cmd
);
  timeunit 1ns;
  timeprecision 1ps;
  import uvf_pkg::*;
  // idle fields flip so a stale byte never looks valid
  initial cmd = '{1'b0, 1'b0, 8'h00, 8'hA5};
  task automatic wr(input logic [7:0] code, input logic [7:0] data);
    @(negedge clk_sys);
    cmd <= '{1'b1, 1'b0, code, data};
    @(negedge clk_sys);
    cmd <= '{1'b0, 1'b0, ~code, ~data};
  endtask
  task automatic rd(input logic [7:0] code, output logic [7:0] data);
    @(negedge clk_sys);
    cmd <= '{1'b0, 1'b1, code, ~cmd.data};
    @(negedge clk_sys);
    cmd <= '{1'b0, 1'b0, ~code, ~cmd.data};
    data = (rdValid === 1'b1) ? rdData : 8'hXX;
  endtask
endmodule
